// *** verification/wfr_pin_model.sv ***
/*
 * Far-side model: wake pins, nmi pin, numbered request pins and reset source.
 * Assumes one clock; every pin changes by non-blocking assignment after a
 * rising edge.
 */
`timescale 1ns/1ps

module wfr_pin_model (
    input  wire logic       sys_clk,
    output logic            sys_rst,
    output logic [5:0]      wakePin,
    output logic            nmiPin,
    output logic [3:0]      extReqPin
);
    // pins are active-low with pull-ups, so they idle high
    initial begin
        sys_rst   = 1'b1;
        wakePin   = 6'h3f;
        nmiPin    = 1'b1;
        extReqPin = 4'hf;
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
    end

    task automatic toggleWake(input int i);
        @(posedge sys_clk);
        wakePin <= wakePin ^ (6'h01 << i);
    endtask : toggleWake

    task automatic setNmi(input logic v);
        @(posedge sys_clk);
        nmiPin <= v;
    endtask : setNmi

    task automatic setExt(input logic [3:0] v);
        @(posedge sys_clk);
        extReqPin <= v;
    endtask : setExt

    // a running reset must stay asserted for at least ten clocks
    task automatic pulseReset(input int n);
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat ((n < 10) ? 10 : n) @(posedge sys_clk);
        sys_rst <= 1'b0;
    endtask : pulseReset
endmodule : wfr_pin_model

// *** verification/wfr_wakeup_nmi_ctrl_bench.sv ***
/*
 * Self-checking bench for the wake-up flag, reset entry and nmi block.
 * Assumes the pin model drives pins and reset; the bench masters Avalon.
 */
`timescale 1ns/1ps
`include "wfr_consts.svh"

module wfr_wakeup_nmi_ctrl_bench;
    logic        sys_clk    = 1'b0;
    logic        sys_rst;
    logic [7:0]  address    = 8'h00;
    logic        read       = 1'b0;
    logic        write      = 1'b0;
    logic [31:0] writedata  = 32'h0;
    logic [3:0]  byteenable = 4'hf;
    logic        nmiAck     = 1'b0;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [5:0]  wakePin;
    logic        nmiPin;
    logic [3:0]  extReqPin;
    logic [3:0]  extReqLevel;
    logic [15:0] pcOut;
    logic        nmiReq, wakeReq, cpuRun, intMask, pcLoad, irq;
    int          fails      = 0;
    int          n_compared = 0;
    logic [31:0] rd, w;
    logic [5:0]  expF, mode, edg, old;
    logic [15:0] vec;

    always #4 sys_clk = ~sys_clk;

    wfr_pin_model pm (.sys_clk(sys_clk), .sys_rst(sys_rst), .wakePin(wakePin),
                      .nmiPin(nmiPin), .extReqPin(extReqPin));

    wfr_wakeup_nmi_ctrl dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .wakePin(wakePin),
        .nmiPin(nmiPin), .extReqPin(extReqPin), .nmiAck(nmiAck), .nmiReq(nmiReq),
        .wakeReq(wakeReq), .extReqLevel(extReqLevel), .cpuRun(cpuRun),
        .intMask(intMask), .pcOut(pcOut), .pcLoad(pcLoad), .irq(irq));

    // ------------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------------
    task automatic results;
        if (fails == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    task automatic cmpW(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmpW

    task automatic cmpB(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmpB

    // waitrequest read here is its value just before the edge
    task automatic busXfer(input logic wr, input logic [5:0] idx, input logic [31:0] d);
        @(posedge sys_clk);
        address   <= {idx, 2'b00};
        writedata <= d;
        write     <= wr;
        read      <= ~wr;
        do @(posedge sys_clk); while (waitrequest !== 1'b0);
        rd = readdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask : busXfer

    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick

    task automatic ackNmi;
        @(posedge sys_clk);
        nmiAck <= 1'b1;
        @(posedge sys_clk);
        nmiAck <= 1'b0;
        tick(1);
    endtask : ackNmi

    function automatic logic [5:0] hits(input logic [5:0] md, input logic [5:0] eg,
                                        input logic [5:0] o, input logic [5:0] n);
        return md & ((eg & ~o & n) | (~eg & o & ~n));
    endfunction : hits

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(2));
        wait (sys_rst === 1'b0);
        tick(4);
        busXfer(1'b0, `WFR_IDX_FLAGS, 32'h0);
        cmpW(rd, 32'h000000c0);
        vec = 16'($urandom);
        busXfer(1'b1, `WFR_IDX_VECTOR, {20'h0, `WFR_VEC_HI_ADDR, vec[15:8]});
        busXfer(1'b1, `WFR_IDX_VECTOR, {20'h0, `WFR_VEC_LO_ADDR, vec[7:0]});
        busXfer(1'b1, `WFR_IDX_CONFIG, 32'h00023f3f);
        fork
            pm.pulseReset(10);
            begin
                tick(5);
                cmpB(cpuRun, 1'b0);
                cmpB(intMask, 1'b1);
            end
        join
        for (int k = 0; k < 20 && pcLoad !== 1'b1; k++) tick(1);
        cmpB(pcLoad, 1'b1);
        cmpW({16'h0, pcOut}, {16'h0, vec});
        cmpB(intMask, 1'b1);
        busXfer(1'b0, `WFR_IDX_CORE, 32'h0);
        cmpW(rd & 32'hffff0003, {vec, 16'h0003});
        busXfer(1'b0, `WFR_IDX_CONFIG, 32'h0);
        cmpW(rd, 32'h0);
        cmpB(irq, 1'b0);
        busXfer(1'b1, `WFR_IDX_EVMASK, 32'h4);
        tick(1);
        cmpB(irq, 1'b1);
        busXfer(1'b1, `WFR_IDX_EVSTAT, 32'h4);
        tick(1);
        cmpB(irq, 1'b0);
        // first pass enables every pin, later passes mix modes and edges
        for (int p = 0; p < 3; p++) begin
            mode = (p == 0) ? 6'h3f : 6'($urandom);
            edg  = 6'($urandom);
            busXfer(1'b1, `WFR_IDX_CONFIG, {14'h0, 2'b10, 2'h0, edg, 2'h0, mode});
            tick(6);
            busXfer(1'b1, `WFR_IDX_FLAGS, 32'h0);
            expF = 6'h00;
            repeat (16) begin
                old = wakePin;
                pm.toggleWake($urandom_range(5, 0));
                tick(6);
                expF |= hits(mode, edg, old, wakePin);
                busXfer(1'b0, `WFR_IDX_FLAGS, 32'h0);
                cmpW(rd, {24'h0, 2'b11, expF});
                w = $urandom;
                busXfer(1'b1, `WFR_IDX_FLAGS, w);
                expF &= w[5:0];
            end
        end
        busXfer(1'b1, `WFR_IDX_CORE, 32'h0);
        tick(1);
        cmpB(wakeReq, |expF);
        busXfer(1'b1, `WFR_IDX_CONFIG, {18'h0, edg, 2'h0, mode});
        tick(1);
        cmpB(wakeReq, 1'b0);
        busXfer(1'b1, `WFR_IDX_CORE, 32'h1);
        tick(1);
        cmpB(intMask, 1'b1);
        // nmi is taken with the mask bit set, on the selected edge only
        for (int s = 0; s < 2; s++) begin
            busXfer(1'b1, `WFR_IDX_CONFIG, {15'h0, 1'(s), 16'h0});
            pm.setNmi(~1'(s));
            tick(6);
            ackNmi();
            pm.setNmi(1'(s));
            tick(6);
            cmpB(nmiReq, 1'b1);
            ackNmi();
            cmpB(nmiReq, 1'b0);
            pm.setNmi(~1'(s));
            tick(6);
            cmpB(nmiReq, 1'b0);
        end
        // the nmi edges above must have left their event bit set
        busXfer(1'b0, `WFR_IDX_EVSTAT, 32'h0);
        cmpW(rd & 32'h00000002, 32'h00000002);
        w = $urandom;
        pm.setExt(w[3:0]);
        tick(4);
        cmpW({28'h0, extReqLevel}, {28'h0, w[3:0]});
        busXfer(1'b0, 6'h10, 32'h0);
        cmpW(rd, 32'h0);
        results();
    end

    initial begin
        #200000;
        fails++;
        results();
    end
endmodule : wfr_wakeup_nmi_ctrl_bench

// *** verilog/wfr_consts.svh ***
/*
 * Offsets, field positions, reset values and counts of the wake-up flag,
 * reset entry and non-maskable edge block.
 * Assumes inclusion by bare name from the block's package and modules.
 */
`ifndef WFR_CONSTS_SVH
`define WFR_CONSTS_SVH

// ----------------------------------------------------------------------
// register word indices (byte address = index * 4)
// ----------------------------------------------------------------------
`define WFR_IDX_FLAGS     6'h00
`define WFR_IDX_CONFIG    6'h01
`define WFR_IDX_EVSTAT    6'h02
`define WFR_IDX_EVMASK    6'h03
`define WFR_IDX_CORE      6'h04
`define WFR_IDX_VECTOR    6'h05

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define WFR_CFG_MODE_LSB  0
`define WFR_CFG_EDGE_LSB  8
`define WFR_CFG_NMIEDGE   16
`define WFR_CFG_WAKEEN    17
`define WFR_EV_WAKE       0
`define WFR_EV_NMI        1
`define WFR_EV_BOOT       2
`define WFR_CORE_IBIT     0
`define WFR_CORE_RUN      1
`define WFR_CORE_PC_LSB   16
`define WFR_VEC_ADDR_LSB  8

// ----------------------------------------------------------------------
// widths, reset values, vector location
// ----------------------------------------------------------------------
`define WFR_NWAKE         6
`define WFR_NEXT          4
`define WFR_NEV           3
`define WFR_RSVD_ONES     2'h3
`define WFR_FLAGS_RST     6'h00
`define WFR_IBIT_RST      1'h1
`define WFR_VEC_HI_ADDR   4'h0
`define WFR_VEC_LO_ADDR   4'h1
`define WFR_MEM_DEPTH     16

`endif

// *** verilog/wfr_pkg.sv ***
/*
 * Types of the wake-up flag, reset entry and non-maskable edge block.
 * Assumes the constants header sits beside it.
 */
`include "wfr_consts.svh"

package wfr_pkg;

    // ------------------------------------------------------------------
    // reset exception sequence
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SEQ_MASK = 2'b00,
        SEQ_HI   = 2'b01,
        SEQ_LO   = 2'b10,
        SEQ_RUN  = 2'b11
    } wfr_seq_t;

    // ------------------------------------------------------------------
    // software configuration
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [`WFR_NWAKE-1:0] portMode;
        logic [`WFR_NWAKE-1:0] edgeSel;
        logic                  nmiEdge;
        logic                  wakeEn;
    } wfr_cfg_t;

    // ------------------------------------------------------------------
    // whole state of the top module
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                  ack;
        logic [31:0]           rdata;
        logic [`WFR_NWAKE-1:0] flags;
        wfr_cfg_t              cfg;
        logic [`WFR_NEV-1:0]   evStat;
        logic [`WFR_NEV-1:0]   evMask;
        logic                  iBit;
        wfr_seq_t              seq;
        logic [7:0]            vecHi;
        logic [15:0]           pc;
        logic                  pcLoad;
        logic                  nmiPend;
        logic [`WFR_NWAKE-1:0] wS1;
        logic [`WFR_NWAKE-1:0] wS2;
        logic [`WFR_NWAKE-1:0] wS3;
        logic [2:0]            nS;
        logic [`WFR_NEXT-1:0]  xS1;
        logic [`WFR_NEXT-1:0]  xS2;
    } wfr_state_t;

endpackage : wfr_pkg

// *** verilog/wfr_vector_mem.sv ***
/*
 * Small byte memory holding the start vector, written from the register
 * bus, read with a registered output.
 * Assumes one clock; contents are not cleared by reset so a vector
 * loaded once survives every later reset.
 */
`timescale 1ns/1ps
`include "wfr_consts.svh"

module wfr_vector_mem (
    input  wire logic       sys_clk,
    input  wire logic       wrEn,
    input  wire logic [3:0] wrAddr,
    input  wire logic [7:0] wrData,
    input  wire logic [3:0] rdAddr,
    output logic      [7:0] rdData
);
    logic [7:0] mem [`WFR_MEM_DEPTH];

    always_ff @(posedge sys_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end

endmodule : wfr_vector_mem

// *** verilog/wfr_wakeup_nmi_ctrl.sv ***
/*
 * Wake-up request flags, reset exception entry and non-maskable edge
 * detector, with an Avalon-MM register slave and an event interrupt.
 * Assumes pins are asynchronous to sys_clk and that sys_rst is the
 * device reset pin already inverted to active high.
 */
// The Avalon-MM interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "wfr_consts.svh"

// Function
// (R1) upper two flag bits always read one
// (R2) flag sets on selected edge, interrupt pin
// (R3) flag clears only by writing zero
// (R4) flags reset to zero, read-write
// (R5) reset halts and initialises all state; the vector memory keeps its contents through reset
// (R6) running reset held low ten clocks
// (R7) power-up reset held until clock stable
// (R8) reset release starts exception sequence
// (R9) first step sets interrupt mask bit
// (R10) fetch vector 0000-0001 into program counter
// (R11) nmi edge chosen by select bit
// (R12) nmi highest priority, ignores mask bit
// (R13) sources: nmi, four request, six wake
// (R14) wake shares vector, per-pin edge, one enable
// (R15) pin counts only in interrupt mode
// (R16) simultaneous edge and clear keeps flag
module wfr_wakeup_nmi_ctrl (
    input  wire logic                  sys_clk,
    input  wire logic                  sys_rst,
    input  wire logic [7:0]            address,
    input  wire logic                  read,
    input  wire logic                  write,
    input  wire logic [31:0]           writedata,
    input  wire logic [3:0]            byteenable,
    output logic      [31:0]           readdata,
    output logic                       waitrequest,
    input  wire logic [`WFR_NWAKE-1:0] wakePin,
    input  wire logic                  nmiPin,
    input  wire logic [`WFR_NEXT-1:0]  extReqPin,
    input  wire logic                  nmiAck,
    output logic                       nmiReq,
    output logic                       wakeReq,
    output logic [`WFR_NEXT-1:0]       extReqLevel,
    output logic                       cpuRun,
    output logic                       intMask,
    output logic [15:0]                pcOut,
    output logic                       pcLoad,
    output logic                       irq
);
    // ------------------------------------------------------------------
    // state and helpers
    // ------------------------------------------------------------------
    wfr_pkg::wfr_state_t st_r;
    wfr_pkg::wfr_state_t st_nxt;
    logic [7:0]          vecRdata;
    logic [3:0]          vecRdAddr;
    logic                vecWr;

    function automatic logic [31:0] laneMerge(input logic [31:0] oldV,
                                              input logic [31:0] newV,
                                              input logic [3:0]  be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (oldV & ~m) | (newV & m);
    endfunction : laneMerge

    function automatic logic [`WFR_NWAKE-1:0] edgeHit(
            input logic [`WFR_NWAKE-1:0] cur,
            input logic [`WFR_NWAKE-1:0] prv,
            input logic [`WFR_NWAKE-1:0] sel);
        // sel one picks the rising edge, zero the falling edge
        return (sel & cur & ~prv) | (~sel & ~cur & prv);
    endfunction : edgeHit

    logic [5:0]  wordIdx;
    logic        acc;
    logic        wrDo;
    logic [31:0] cfgWord;
    logic [31:0] coreWord;
    logic [`WFR_NWAKE-1:0] wakeEdge;
    logic        nmiEdgeHit;

    assign wordIdx = address[7:2];
    assign acc     = read | write;
    assign wrDo    = write & st_r.ack;
    assign vecWr   = wrDo && (wordIdx == `WFR_IDX_VECTOR) && byteenable[0];

    // while the sequence runs the memory port belongs to the vector fetch
    assign vecRdAddr = (st_r.seq == wfr_pkg::SEQ_MASK) ? `WFR_VEC_HI_ADDR
                                                       : `WFR_VEC_LO_ADDR;

    assign cfgWord = {14'h0000, st_r.cfg.wakeEn, st_r.cfg.nmiEdge,
                      2'h0, st_r.cfg.edgeSel, 2'h0, st_r.cfg.portMode};
    assign coreWord = {st_r.pc, 14'h0000, (st_r.seq == wfr_pkg::SEQ_RUN),
                       st_r.iBit};

    // R15 gates the pin through its mode bit
    assign wakeEdge   = edgeHit(st_r.wS2, st_r.wS3, st_r.cfg.edgeSel)
                        & st_r.cfg.portMode; // see (R2) see (R15) see (R14)
    assign nmiEdgeHit = st_r.cfg.nmiEdge ? (st_r.nS[1] & ~st_r.nS[2])
                                         : (~st_r.nS[1] & st_r.nS[2]); // see (R11)

    wfr_vector_mem u_vector_mem (
        .sys_clk (sys_clk),
        .wrEn    (vecWr),
        .wrAddr  (writedata[`WFR_VEC_ADDR_LSB +: 4]),
        .wrData  (writedata[7:0]),
        .rdAddr  (vecRdAddr),
        .rdData  (vecRdata)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [`WFR_NWAKE-1:0] clr;
        logic [`WFR_NEV-1:0]   evSet;
        logic [31:0]           merged;
        clr    = '0;
        evSet  = '0;
        merged = '0;
        st_nxt = st_r;

        // pin synchronisers; edge detectors compare the second and third stages
        st_nxt.wS1 = wakePin;
        st_nxt.wS2 = st_r.wS1;
        st_nxt.wS3 = st_r.wS2;
        st_nxt.nS  = {st_r.nS[1], st_r.nS[0], nmiPin};
        st_nxt.xS1 = extReqPin; // see (R13)
        st_nxt.xS2 = st_r.xS1;

        // bus slave: one wait cycle, read data registered for the ack cycle
        st_nxt.ack = acc & ~st_r.ack;
        if (acc && !st_r.ack) begin
            unique case (wordIdx)
                `WFR_IDX_FLAGS:  st_nxt.rdata = {24'h000000, `WFR_RSVD_ONES,
                                                 st_r.flags}; // see (R1) see (R4)
                `WFR_IDX_CONFIG: st_nxt.rdata = cfgWord;
                `WFR_IDX_EVSTAT: st_nxt.rdata = {29'h0, st_r.evStat};
                `WFR_IDX_EVMASK: st_nxt.rdata = {29'h0, st_r.evMask};
                `WFR_IDX_CORE:   st_nxt.rdata = coreWord;
                default:         st_nxt.rdata = 32'h00000000;
            endcase
        end

        if (wrDo) begin
            unique case (wordIdx)
                `WFR_IDX_FLAGS: begin
                    if (byteenable[0]) begin
                        clr = ~writedata[`WFR_NWAKE-1:0]; // see (R3)
                    end
                end
                `WFR_IDX_CONFIG: begin
                    merged = laneMerge(cfgWord, writedata, byteenable);
                    st_nxt.cfg.portMode = merged[`WFR_CFG_MODE_LSB +: `WFR_NWAKE];
                    st_nxt.cfg.edgeSel  = merged[`WFR_CFG_EDGE_LSB +: `WFR_NWAKE];
                    st_nxt.cfg.nmiEdge  = merged[`WFR_CFG_NMIEDGE];
                    st_nxt.cfg.wakeEn   = merged[`WFR_CFG_WAKEEN];
                end
                `WFR_IDX_EVSTAT: begin
                    if (byteenable[0]) begin
                        st_nxt.evStat = st_r.evStat & ~writedata[`WFR_NEV-1:0];
                    end
                end
                `WFR_IDX_EVMASK: begin
                    if (byteenable[0]) begin
                        st_nxt.evMask = writedata[`WFR_NEV-1:0];
                    end
                end
                `WFR_IDX_CORE: begin
                    if (byteenable[0] && st_r.seq == wfr_pkg::SEQ_RUN) begin
                        st_nxt.iBit = writedata[`WFR_CORE_IBIT];
                    end
                end
                default: begin
                end
            endcase
        end

        // set after clear, so an edge in the clearing cycle survives
        st_nxt.flags = (st_r.flags & ~clr) | wakeEdge; // see (R16) see (R2)

        // reset exception: mask, fetch high byte, fetch low byte, run
        st_nxt.pcLoad = 1'b0;
        unique case (st_r.seq)
            wfr_pkg::SEQ_MASK: begin
                st_nxt.iBit = 1'b1; // see (R9) see (R8)
                st_nxt.seq  = wfr_pkg::SEQ_HI;
            end
            wfr_pkg::SEQ_HI: begin
                st_nxt.vecHi = vecRdata;
                st_nxt.seq   = wfr_pkg::SEQ_LO;
            end
            wfr_pkg::SEQ_LO: begin
                st_nxt.pc     = {st_r.vecHi, vecRdata}; // see (R10)
                st_nxt.pcLoad = 1'b1;
                st_nxt.seq    = wfr_pkg::SEQ_RUN;
                evSet[`WFR_EV_BOOT] = 1'b1;
            end
            wfr_pkg::SEQ_RUN: begin
            end
        endcase

        // no nmi is taken until the sequence has handed over to the core
        if (nmiAck) begin
            st_nxt.nmiPend = 1'b0;
        end
        if (nmiEdgeHit && st_r.seq == wfr_pkg::SEQ_RUN) begin
            st_nxt.nmiPend = 1'b1; // see (R11)
            evSet[`WFR_EV_NMI] = 1'b1;
        end
        evSet[`WFR_EV_WAKE] = |wakeEdge;
        st_nxt.evStat = st_nxt.evStat | evSet;
    end

    // ------------------------------------------------------------------
    // registers; the async reset is the device reset pin
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r       <= '0; // see (R5)
            st_r.flags <= `WFR_FLAGS_RST; // see (R4)
            st_r.iBit  <= `WFR_IBIT_RST;
            st_r.seq   <= wfr_pkg::SEQ_MASK;
            // wake and nmi synchronisers start at the pins' pulled-up idle level, else
            // the first edges after reset would see a false rising edge
            st_r.wS1   <= '1;
            st_r.wS2   <= '1;
            st_r.wS3   <= '1;
            st_r.nS    <= '1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign readdata    = st_r.rdata;
    assign waitrequest = acc & ~st_r.ack;
    assign nmiReq      = st_r.nmiPend; // see (R12)
    assign wakeReq     = (|st_r.flags) & st_r.cfg.wakeEn & ~st_r.iBit; // see (R14)
    assign extReqLevel = st_r.xS2;
    assign cpuRun      = (st_r.seq == wfr_pkg::SEQ_RUN);
    assign intMask     = st_r.iBit;
    assign pcOut       = st_r.pc;
    assign pcLoad      = st_r.pcLoad;
    assign irq         = |(st_r.evStat & st_r.evMask);

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_reserved_ones: assert property ( // see (R1)
        (read && !waitrequest && wordIdx == `WFR_IDX_FLAGS) |-> readdata[7:6] == 2'b11)
        else $error("reserved flag bits did not read as one");

    a_flag_edge_set: assert property ( // see (R2)
        wakeEdge[0] |=> st_r.flags[0])
        else $error("enabled wake edge did not set its flag");

    a_flag_zero_clear: assert property ( // see (R3)
        (wrDo && wordIdx == `WFR_IDX_FLAGS && byteenable[0] && !writedata[0]
         && !wakeEdge[0]) |=> !st_r.flags[0])
        else $error("writing zero did not clear the flag");

    a_flag_holds: assert property ( // see (R3)
        (st_r.flags[0] && !(wrDo && wordIdx == `WFR_IDX_FLAGS)) |=> st_r.flags[0])
        else $error("flag dropped without a clearing write");

    a_mode_gate: assert property ( // see (R15)
        (!st_r.cfg.portMode[1] && !st_r.flags[1]) |=> !st_r.flags[1])
        else $error("flag set on a pin not in interrupt mode");

    a_clear_loses: assert property ( // see (R16)
        (wakeEdge[2] && wrDo && wordIdx == `WFR_IDX_FLAGS) |=> st_r.flags[2])
        else $error("edge lost to a simultaneous clear");

    a_mask_first: assert property ( // see (R9)
        (st_r.seq == wfr_pkg::SEQ_HI) |-> st_r.iBit ##2 pcLoad)
        else $error("sequence did not mask then load the vector");

    // vector bytes are unknown until software loads them, hence case equality
    a_pc_vector: assert property ( // see (R10)
        (st_r.seq == wfr_pkg::SEQ_LO) |=> pcLoad && cpuRun
            && (pcOut === {$past(st_r.vecHi), $past(vecRdata)}))
        else $error("program counter not loaded from the vector");

    a_nmi_edge: assert property ( // see (R11)
        (nmiEdgeHit && cpuRun) |=> nmiReq)
        else $error("selected nmi edge not detected");

    a_nmi_unmasked: assert property ( // see (R12)
        (nmiEdgeHit && cpuRun && intMask) |=> nmiReq)
        else $error("nmi blocked by the mask bit");

    a_wake_shared: assert property ( // see (R14)
        wakeReq |-> (|st_r.flags) && st_r.cfg.wakeEn && !intMask)
        else $error("wake request without flag, enable and clear mask");

    a_wake_raised: assert property ( // see (R14)
        ((|st_r.flags) && st_r.cfg.wakeEn && !intMask) |-> wakeReq)
        else $error("wake request missing with flag, enable and clear mask");

endmodule : wfr_wakeup_nmi_ctrl
